// ---- include/cfg5_map.svh ----
`ifndef CFG5_MAP_SVH
`define CFG5_MAP_SVH

// Register indices; byte address is the index times four
`define IDX_OFFSET_R1    8'h70
`define IDX_OFFSET_LOC   8'h71
`define IDX_OFFSET_R2    8'h72
`define IDX_CFG5         8'h7C
`define IDX_LOCK         8'h80
`define IDX_R1_LIMIT     8'h81
`define IDX_AUX_CTRL     8'h82
`define IDX_STATUS       8'h83
`define IDX_R1_READING   8'h84
`define IDX_TIMER        8'h85
`define IDX_PIN_GROUP    8'h86

// Address decode: index bits and bits that must be zero
`define ADDR_IDX_LSB     2
`define ADDR_IDX_MSB     9
`define ADDR_TOP_LSB     10

// Reset values
`define CFG5_RESET       8'h01
`define LIMIT_RESET      8'h64
`define OFFSET_RESET     8'h00

// Fields of the format and pin configuration register
`define BIT_SIGNED       0
`define BIT_OFF_RANGE    1
`define BIT_AUX_DIR      2
`define BIT_AUX_POL      3
`define BIT_VID_SEL      4
`define BIT_R1_OT        5

// Fields of the own control and status registers
`define BIT_LOCK         0
`define BIT_AUX_EN       0
`define BIT_AUX_LEVEL    1
`define ST_OT_DRIVE      0
`define ST_OT_SEEN       1
`define ST_AUX_IN        2
`define ST_OT_PIN        3
`define ST_LIMIT_OFF     4

// Temperature coding and timer ceiling
`define OB_BIAS          10'h040
`define OB_MIN_TEMP      8'hC0
`define LIMIT_OFF_TC     8'h80
`define LIMIT_OFF_OB     8'h00
`define TIMER_MAX        16'hFFFF

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- include/cfg5_pkg.sv ----
package cfg5_pkg;
   typedef logic [11:0]        addr_t;
   typedef logic [31:0]        word_t;
   typedef logic [7:0]         code_t;
   typedef logic signed [11:0] half_t;
   typedef logic signed [10:0] offset_half_t;
   typedef enum logic {
      OT_LISTEN = 1'b0,
      OT_DRIVE  = 1'b1
   } ot_state_t;
endpackage

// ---- include/reg_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
   logic            wr_en;
   cfg5_pkg::addr_t wr_addr;
   cfg5_pkg::word_t wr_data;
   logic [3:0]      wr_strb;
   logic            wr_hit;
   cfg5_pkg::addr_t rd_addr;
   cfg5_pkg::word_t rd_data;
   logic            rd_hit;
   modport initiator (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                      input  wr_hit, rd_data, rd_hit);
   modport target    (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                      output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // Two flops; the first is read only by the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_reg     <= '0;
         pin_sync_out <= '0;
      end else begin
         meta_reg     <= pin_in;
         pin_sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/axil_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfg5_map.svh"
module axil_slave (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst,
   // Write channels
   input  wire cfg5_pkg::addr_t awaddr,
   input  wire logic            awvalid,
   output var  logic            awready,
   input  wire cfg5_pkg::word_t wdata,
   input  wire logic [3:0]      wstrb,
   input  wire logic            wvalid,
   output var  logic            wready,
   output var  logic [1:0]      bresp,
   output var  logic            bvalid,
   input  wire logic            bready,
   // Read channels
   input  wire cfg5_pkg::addr_t araddr,
   input  wire logic            arvalid,
   output var  logic            arready,
   output var  cfg5_pkg::word_t rdata,
   output var  logic [1:0]      rresp,
   output var  logic            rvalid,
   input  wire logic            rready,
   // Register side
   reg_bus_if.initiator         bus
);
   import cfg5_pkg::*;

   logic  wr_fire;
   logic  rd_fire;

   // Write fires once address and data are both held
   assign wr_fire      = !awready && !wready && !bvalid;
   assign rd_fire      = !arready && !rvalid;
   assign bus.wr_en    = wr_fire;

   // Write address capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awready     <= 1'b1;
         bus.wr_addr <= '0;
      end else if (awvalid && awready) begin
         awready     <= 1'b0;
         bus.wr_addr <= awaddr;
      end else if (wr_fire) begin
         awready     <= 1'b1;
      end
   end

   // Write data capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wready      <= 1'b1;
         bus.wr_data <= '0;
         bus.wr_strb <= '0;
      end else if (wvalid && wready) begin
         wready      <= 1'b0;
         bus.wr_data <= wdata;
         bus.wr_strb <= wstrb;
      end else if (wr_fire) begin
         wready      <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= bus.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read address capture and answer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         arready     <= 1'b1;
         bus.rd_addr <= '0;
         rvalid      <= 1'b0;
         rdata       <= '0;
         rresp       <= `RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready     <= 1'b0;
            bus.rd_addr <= araddr;
         end else if (rd_fire) begin
            arready     <= 1'b1;
         end
         if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= bus.rd_data;
            rresp  <= bus.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/thermal_format_pin_config_register.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Format bit 0 set selects signed temperature range
// - Format bit 0 clear selects 64-degree offset binary
// - Format change reinterprets the limit and reading; offsets stay two's complement
// - Range bit 0: offsets in half degrees
// - Range bit 1: offsets in whole degrees
// - Range applies to three offset registers only
// - Direction bit: 0 input, 1 output
// - Polarity bit: 0 active low, 1 high
// - Group select: 0 voltage-ID, 1 general purpose
// - Remote1 enable lets over-temperature drive pin
// - Offset mode limit -64 disables pin drive
// - Signed mode limit -128 disables pin drive
// - Reset value 0x01, signed format
// - Lock bit makes register read-only
`include "cfg5_map.svh"
module thermal_format_pin_config_register (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // AXI4-Lite write channels
   input  wire cfg5_pkg::addr_t        s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire cfg5_pkg::word_t        s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read channels
   input  wire cfg5_pkg::addr_t        s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  cfg5_pkg::word_t        s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Remote 1 measurement, signed degrees
   input  wire cfg5_pkg::code_t        remote1_temp,
   // Auxiliary pin
   input  wire logic                   aux_pin_in,
   output var  logic                   aux_pin_out,
   output var  logic                   aux_pin_oe_n,
   // Over-temperature pin, open drain, active low
   input  wire logic                   overtemp_pin_in,
   output var  logic                   overtemp_pin_out,
   output var  logic                   overtemp_pin_oe_n,
   // Shared pin group
   input  wire logic [4:0]             group_pins_in,
   output var  logic [4:0]             voltage_id,
   // Decoded temperature values
   output var  cfg5_pkg::code_t        remote1_temp_code,
   output var  cfg5_pkg::offset_half_t offset_remote1_half,
   output var  cfg5_pkg::offset_half_t offset_local_half,
   output var  cfg5_pkg::offset_half_t offset_remote2_half
);
   import cfg5_pkg::*;

   // Register bus between bus slave and register file
   reg_bus_if bus ();

   axil_slave u_axil (
      .core_clk (core_clk),
      .rst      (rst),
      .awaddr   (s_axi_awaddr),
      .awvalid  (s_axi_awvalid),
      .awready  (s_axi_awready),
      .wdata    (s_axi_wdata),
      .wstrb    (s_axi_wstrb),
      .wvalid   (s_axi_wvalid),
      .wready   (s_axi_wready),
      .bresp    (s_axi_bresp),
      .bvalid   (s_axi_bvalid),
      .bready   (s_axi_bready),
      .araddr   (s_axi_araddr),
      .arvalid  (s_axi_arvalid),
      .arready  (s_axi_arready),
      .rdata    (s_axi_rdata),
      .rresp    (s_axi_rresp),
      .rvalid   (s_axi_rvalid),
      .rready   (s_axi_rready),
      .bus      (bus.initiator)
   );

   // Pin synchronisers
   logic       aux_in_sync;
   logic       ot_in_sync;
   logic [4:0] group_sync;

   pin_sync #(.WIDTH(1)) u_sync_aux (
      .core_clk     (core_clk),
      .rst          (rst),
      .pin_in       (aux_pin_in),
      .pin_sync_out (aux_in_sync)
   );

   pin_sync #(.WIDTH(1)) u_sync_ot (
      .core_clk     (core_clk),
      .rst          (rst),
      .pin_in       (overtemp_pin_in),
      .pin_sync_out (ot_in_sync)
   );

   pin_sync #(.WIDTH(5)) u_sync_group (
      .core_clk     (core_clk),
      .rst          (rst),
      .pin_in       (group_pins_in),
      .pin_sync_out (group_sync)
   );

   // Register index of a byte address, and whether it lies in the map window
   function automatic code_t idx_of(input addr_t a);
      idx_of = a[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
   endfunction

   function automatic logic in_window(input addr_t a);
      in_window = (a[11:`ADDR_TOP_LSB] == 2'h0) && (a[1:0] == 2'h0);
   endfunction

   // Offset code to half degrees under the selected range
   function automatic offset_half_t offset_to_half(input code_t c, input logic whole);
      offset_half_t s;
      s = offset_half_t'($signed(c));
      offset_to_half = whole ? offset_half_t'(s <<< 1) : s;
   endfunction

   // Limit code to half degrees under the selected format
   function automatic half_t limit_to_half(input code_t c, input logic signed_fmt);
      logic signed [9:0] deg;
      deg = signed_fmt ? 10'($signed(c)) : $signed({2'h0, c} - `OB_BIAS);
      limit_to_half = half_t'(deg) <<< 1;
   endfunction

   // Stored registers
   code_t        cfg5_reg;
   logic         lock_reg;
   code_t        limit_reg;
   code_t        offset_reg [3];
   logic [1:0]   aux_ctrl_reg;
   logic         ot_seen_reg;
   logic [15:0]  timer_reg;
   ot_state_t    ot_state_reg;
   ot_state_t    ot_state_next;

   // Field views
   logic  signed_range_select;
   logic  offset_range_select;
   logic  aux_pin_direction;
   logic  aux_pin_polarity;
   logic  voltage_id_pin_select;
   logic  remote1_overtemp_enable;

   assign signed_range_select     = cfg5_reg[`BIT_SIGNED];
   assign offset_range_select     = cfg5_reg[`BIT_OFF_RANGE];
   assign aux_pin_direction       = cfg5_reg[`BIT_AUX_DIR];
   assign aux_pin_polarity        = cfg5_reg[`BIT_AUX_POL];
   assign voltage_id_pin_select   = cfg5_reg[`BIT_VID_SEL];
   assign remote1_overtemp_enable = cfg5_reg[`BIT_R1_OT];

   // Write decode; only the low byte lane carries register data
   logic  wr_lo;
   code_t wr_idx;
   code_t wr_byte;

   assign wr_lo   = bus.wr_en && bus.wr_strb[0] && in_window(bus.wr_addr);
   assign wr_idx  = idx_of(bus.wr_addr);
   assign wr_byte = bus.wr_data[7:0];

   // Format and pin configuration, frozen by the lock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg5_reg <= `CFG5_RESET;
      end else if (wr_lo && wr_idx == `IDX_CFG5 && !lock_reg) begin
         cfg5_reg <= wr_byte;
      end
   end

   // Lock bit sets once and clears only by reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_reg <= 1'b0;
      end else if (wr_lo && wr_idx == `IDX_LOCK && wr_byte[`BIT_LOCK]) begin
         lock_reg <= 1'b1;
      end
   end

   // Remote 1 over-temperature limit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         limit_reg <= `LIMIT_RESET;
      end else if (wr_lo && wr_idx == `IDX_R1_LIMIT) begin
         limit_reg <= wr_byte;
      end
   end

   // Three temperature offset registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            offset_reg[i] <= `OFFSET_RESET;
         end
      end else if (wr_lo) begin
         for (int i = 0; i < 3; i++) begin
            if (wr_idx == code_t'(`IDX_OFFSET_R1 + i)) begin
               offset_reg[i] <= wr_byte;
            end
         end
      end
   end

   // Auxiliary pin control: enable and logical level
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aux_ctrl_reg <= 2'h0;
      end else if (wr_lo && wr_idx == `IDX_AUX_CTRL) begin
         aux_ctrl_reg <= wr_byte[1:0];
      end
   end

   // Over-temperature decision under the current format
   logic  limit_disabled;
   logic  over_limit;
   half_t temp_half;
   half_t limit_half;

   assign limit_disabled = signed_range_select ?
                           (limit_reg == `LIMIT_OFF_TC) :
                           (limit_reg == `LIMIT_OFF_OB);
   assign limit_half = limit_to_half(limit_reg, signed_range_select);
   assign temp_half  = half_t'(($signed(remote1_temp) <<< 1))
                     + half_t'(offset_to_half(offset_reg[0], offset_range_select));
   assign over_limit = (temp_half > limit_half) && !limit_disabled;

   // Pin state: drive low on over-temperature, otherwise listen as timer input
   always_comb begin
      ot_state_next = ot_state_reg;
      unique case (ot_state_reg)
         OT_LISTEN: begin
            if (remote1_overtemp_enable && over_limit) begin
               ot_state_next = OT_DRIVE;
            end
         end
         OT_DRIVE: begin
            if (!remote1_overtemp_enable || !over_limit) begin
               ot_state_next = OT_LISTEN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ot_state_reg <= OT_LISTEN;
      end else begin
         ot_state_reg <= ot_state_next;
      end
   end

   // Open-drain output: pulls low only while driving
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overtemp_pin_out  <= 1'b0;
         overtemp_pin_oe_n <= 1'b1;
      end else begin
         overtemp_pin_out  <= 1'b0;
         overtemp_pin_oe_n <= (ot_state_next != OT_DRIVE);
      end
   end

   // Timer counts cycles the pin is held low by others; write clears only while not counting
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_reg <= 16'h0000;
      end else if (ot_state_reg == OT_LISTEN && !ot_in_sync) begin
         if (timer_reg != `TIMER_MAX) begin
            timer_reg <= timer_reg + 16'h0001;
         end
      end else if (wr_lo && wr_idx == `IDX_TIMER) begin
         timer_reg <= 16'h0000;
      end
   end

   // Sticky over-temperature seen flag; a new event wins over the clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ot_seen_reg <= 1'b0;
      end else if (ot_state_reg == OT_DRIVE) begin
         ot_seen_reg <= 1'b1;
      end else if (wr_lo && wr_idx == `IDX_STATUS && wr_byte[`ST_OT_SEEN]) begin
         ot_seen_reg <= 1'b0;
      end
   end

   // Auxiliary pin drive from direction, polarity and enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aux_pin_out  <= 1'b0;
         aux_pin_oe_n <= 1'b1;
      end else begin
         aux_pin_oe_n <= !(aux_ctrl_reg[`BIT_AUX_EN] && aux_pin_direction);
         aux_pin_out  <= aux_pin_polarity ? aux_ctrl_reg[`BIT_AUX_LEVEL]
                                          : !aux_ctrl_reg[`BIT_AUX_LEVEL];
      end
   end

   // Shared pins: voltage-ID output only when group is in that mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         voltage_id <= 5'h00;
      end else begin
         voltage_id <= voltage_id_pin_select ? 5'h00 : group_sync;
      end
   end

   // Reading and offsets in the selected format and range
   always_ff @(posedge core_clk) begin
      if (rst) begin
         remote1_temp_code   <= 8'h00;
         offset_remote1_half <= '0;
         offset_local_half   <= '0;
         offset_remote2_half <= '0;
      end else begin
         if (signed_range_select) begin
            remote1_temp_code <= remote1_temp;
         end else if ($signed(remote1_temp) < $signed(`OB_MIN_TEMP)) begin
            remote1_temp_code <= 8'h00;
         end else begin
            remote1_temp_code <= 8'(remote1_temp + `OB_BIAS);
         end
         offset_remote1_half <= offset_to_half(offset_reg[0], offset_range_select);
         offset_local_half   <= offset_to_half(offset_reg[1], offset_range_select);
         offset_remote2_half <= offset_to_half(offset_reg[2], offset_range_select);
      end
   end

   // Write hit decode
   always_comb begin
      bus.wr_hit = 1'b0;
      if (in_window(bus.wr_addr)) begin
         unique case (wr_idx)
            `IDX_OFFSET_R1, `IDX_OFFSET_LOC, `IDX_OFFSET_R2,
            `IDX_CFG5, `IDX_LOCK, `IDX_R1_LIMIT, `IDX_AUX_CTRL,
            `IDX_STATUS, `IDX_R1_READING, `IDX_TIMER,
            `IDX_PIN_GROUP: bus.wr_hit = 1'b1;
            default:        bus.wr_hit = 1'b0;
         endcase
      end
   end

   // Read decode; narrow registers sit in the low bits
   code_t rd_idx;
   code_t status_byte;

   assign rd_idx      = idx_of(bus.rd_addr);
   assign status_byte = {3'h0, limit_disabled, ot_in_sync, aux_in_sync,
                         ot_seen_reg, ot_state_reg == OT_DRIVE};

   always_comb begin
      bus.rd_data = 32'h0000_0000;
      bus.rd_hit  = in_window(bus.rd_addr);
      if (in_window(bus.rd_addr)) begin
         unique case (rd_idx)
            `IDX_OFFSET_R1:  bus.rd_data[7:0] = offset_reg[0];
            `IDX_OFFSET_LOC: bus.rd_data[7:0] = offset_reg[1];
            `IDX_OFFSET_R2:  bus.rd_data[7:0] = offset_reg[2];
            `IDX_CFG5:       bus.rd_data[7:0] = cfg5_reg;
            `IDX_LOCK:       bus.rd_data[0]   = lock_reg;
            `IDX_R1_LIMIT:   bus.rd_data[7:0] = limit_reg;
            `IDX_AUX_CTRL:   bus.rd_data[1:0] = aux_ctrl_reg;
            `IDX_STATUS:     bus.rd_data[7:0] = status_byte;
            `IDX_R1_READING: bus.rd_data[7:0] = remote1_temp_code;
            `IDX_TIMER:      bus.rd_data[15:0] = timer_reg;
            `IDX_PIN_GROUP:  bus.rd_data[4:0] = voltage_id_pin_select ? group_sync : 5'h00;
            default:         bus.rd_hit = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- sim/thermal_format_pin_config_register_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfg5_map.svh"
module thermal_format_pin_config_register_asserts (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Write request
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   // Measurement and pins
   input wire logic [7:0]  remote1_temp,
   input wire logic        aux_pin_out,
   input wire logic        aux_pin_oe_n,
   input wire logic        overtemp_pin_out,
   input wire logic        overtemp_pin_oe_n,
   input wire logic [4:0]  voltage_id,
   // Decoded values
   input wire logic [7:0]  remote1_temp_code,
   input wire logic [10:0] offset_remote1_half,
   input wire logic [10:0] offset_local_half,
   input wire logic [10:0] offset_remote2_half
);
   import cfg5_pkg::*;
   code_t cfg_sh;
   code_t aux_sh;
   code_t lim_sh;
   logic  lock_sh;
   code_t ob_code;
   logic  wtk;
   // Write taken, low byte enabled
   assign wtk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   // Reading in offset binary, clamped
   assign ob_code = (remote1_temp[7:6] == 2'b10) ? 8'h00 : remote1_temp + 8'h40;
   // Shadows of pin-steering registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_sh  <= `CFG5_RESET;
         aux_sh  <= 8'h00;
         lim_sh  <= `LIMIT_RESET;
         lock_sh <= 1'b0;
      end else if (wtk) begin
         if (s_axi_awaddr == {2'b00, `IDX_CFG5, 2'b00} && !lock_sh) cfg_sh <= s_axi_wdata[7:0];
         if (s_axi_awaddr == {2'b00, `IDX_AUX_CTRL, 2'b00}) aux_sh <= s_axi_wdata[7:0];
         if (s_axi_awaddr == {2'b00, `IDX_R1_LIMIT, 2'b00}) lim_sh <= s_axi_wdata[7:0];
         if (s_axi_awaddr == {2'b00, `IDX_LOCK, 2'b00}) lock_sh <= lock_sh | s_axi_wdata[0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Past reset
   sequence s_live;
      !$past(rst);
   endsequence
   a_aux_drive:
      assert property (s_live |-> aux_pin_oe_n == !($past(aux_sh[0], 2) && $past(cfg_sh[2], 2)))
      else $error("aux drive");
   a_aux_level:
      assert property (s_live |-> aux_pin_out == ($past(cfg_sh[3], 2) ~^ $past(aux_sh[1], 2)))
      else $error("aux level");
   a_ot_gate:
      assert property (!overtemp_pin_oe_n |-> $past(cfg_sh[5], 2)) else $error("ot when off");
   a_ot_open_drain:
      assert property (overtemp_pin_out == 1'b0) else $error("ot high");
   a_limit_off:
      assert property (s_live ##0 ($past(lim_sh, 2) == ($past(cfg_sh[0], 2) ? 8'h80 : 8'h00))
         |-> overtemp_pin_oe_n) else $error("ot limit off");
   a_vid_gate:
      assert property (s_live ##0 $past(cfg_sh[4], 2) |-> voltage_id == 5'h00)
      else $error("vid shown");
   a_code_signed:
      assert property (s_live ##0 $past(cfg_sh[0], 2) |-> remote1_temp_code == $past(remote1_temp))
      else $error("signed code");
   a_code_offset:
      assert property (s_live ##0 !$past(cfg_sh[0], 2) |-> remote1_temp_code == $past(ob_code))
      else $error("offset code");
   a_offset_whole:
      assert property (s_live ##0 $past(cfg_sh[1], 2) |->
         !(offset_remote1_half[0] || offset_local_half[0] || offset_remote2_half[0]))
      else $error("odd offset");
endmodule
bind thermal_format_pin_config_register
   thermal_format_pin_config_register_asserts thermal_format_pin_config_register_asserts_i (.*);
`default_nettype wire

// ---- sim/thermal_format_pin_config_register_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfg5_map.svh"
module thermal_format_pin_config_register_tb_top;
   import cfg5_pkg::*;
   // Design ports and bench state
   logic         core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic         s_axi_rready, aux_pin_in, aux_pin_out, aux_pin_oe_n;
   logic         overtemp_pin_in, overtemp_pin_out, overtemp_pin_oe_n;
   addr_t        s_axi_awaddr, s_axi_araddr;
   word_t        s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0]   s_axi_wstrb;
   logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
   code_t        remote1_temp, remote1_temp_code;
   logic [4:0]   group_pins_in, voltage_id;
   offset_half_t offset_remote1_half, offset_local_half, offset_remote2_half;
   int           err_count = 0;
   int           n_compared = 0;
   // Pins: open drain pulled up, aux low when released
   assign overtemp_pin_in = overtemp_pin_oe_n | overtemp_pin_out;
   assign aux_pin_in = !aux_pin_oe_n && aux_pin_out;
   thermal_format_pin_config_register thermal_format_pin_config_register_i (.*);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input word_t got, input word_t exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Write: AW and W together, each dropped when taken
   task automatic wr(input code_t idx, input code_t d);
      @(posedge core_clk);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= 32'(d);
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input code_t idx);
      @(posedge core_clk);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Settle time
   task automatic wt;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic wc(input code_t d);
      wr(`IDX_CFG5, d);
      wt();
   endtask
   task automatic t_reset;
      rd(`IDX_CFG5);
      chk(rd_d, 32'h0000_0001);
   endtask
   task automatic t_format;
      remote1_temp <= 8'hf0;
      wc(8'h00);
      chk(remote1_temp_code, 8'h30);
      remote1_temp <= 8'hb0;
      wt();
      chk(remote1_temp_code, 8'h00);
      wc(8'h01);
      chk(remote1_temp_code, 8'hb0);
   endtask
   task automatic t_overtemp;
      remote1_temp <= 8'h28;
      wr(`IDX_R1_LIMIT, 8'h1e);
      wc(8'h21);
      chk(overtemp_pin_oe_n, 1'b0);
      wc(8'h01);
      chk(overtemp_pin_oe_n, 1'b1);
      wc(8'h21);
      wr(`IDX_R1_LIMIT, 8'h80);
      wt();
      chk(overtemp_pin_oe_n, 1'b1);
      wc(8'h20);
      wr(`IDX_R1_LIMIT, 8'h00);
      wt();
      chk(overtemp_pin_oe_n, 1'b1);
      wr(`IDX_R1_LIMIT, 8'h5e);
      wt();
      chk(overtemp_pin_oe_n, 1'b0);
   endtask
   task automatic t_offset;
      wc(8'h00);
      wr(`IDX_OFFSET_R1, 8'hfe);
      wr(`IDX_OFFSET_LOC, 8'h05);
      wr(`IDX_OFFSET_R2, 8'h80);
      wt();
      chk(offset_remote1_half, -2);
      chk(offset_local_half, 5);
      chk(offset_remote2_half, -128);
      wc(8'h02);
      chk(offset_remote1_half, -4);
      chk(offset_local_half, 10);
      chk(offset_remote2_half, -256);
   endtask
   task automatic t_aux;
      wr(`IDX_AUX_CTRL, 8'h03);
      wc(8'h0c);
      chk(aux_pin_oe_n, 1'b0);
      chk(aux_pin_out, 1'b1);
      wc(8'h04);
      chk(aux_pin_out, 1'b0);
      wc(8'h00);
      chk(aux_pin_oe_n, 1'b1);
   endtask
   task automatic t_vid;
      group_pins_in <= 5'h15;
      wc(8'h00);
      chk(voltage_id, 5'h15);
      wc(8'h10);
      chk(voltage_id, 5'h00);
      rd(`IDX_PIN_GROUP);
      chk(rd_d, 32'h0000_0015);
   endtask
   task automatic t_lock;
      wr(`IDX_CFG5, 8'hc5);
      rd(`IDX_CFG5);
      chk(rd_d, 32'h0000_00c5);
      wr(`IDX_LOCK, 8'h01);
      wr(`IDX_CFG5, 8'h00);
      chk(rsp, `RESP_OKAY);
      rd(`IDX_CFG5);
      chk(rd_d, 32'h0000_00c5);
      rd(8'h7f);
      chk(rsp, `RESP_SLVERR);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, remote1_temp, group_pins_in} = '0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_format();
      t_overtemp();
      t_offset();
      t_aux();
      t_vid();
      t_lock();
      stop_test();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      stop_test();
   end
endmodule
`default_nettype wire
